/* rtl/ecid_defs.vh */
// constants for the eeprom command and identification block
// assumes a byte-wide register port and a 64-byte eeprom array
`ifndef ECID_DEFS_VH
`define ECID_DEFS_VH

// ========================================
// register offsets
`define ECID_ADDR_BYTE_POINTER 8'h25
`define ECID_ADDR_BYTE_BUFFER 8'h26
`define ECID_ADDR_COMMAND_CODE 8'h27
`define ECID_ADDR_IDENTIFICATION 8'h28
`define ECID_ADDR_CFG_RESERVED 8'h2B
`define ECID_ADDR_CFG_FIRST 8'h30
`define ECID_ADDR_CFG_LAST 8'h37
`define ECID_ADDR_USER_LAST 8'h2A

// ========================================
// command codes
`define ECID_CMD_IDLE 8'h00
`define ECID_CMD_UPDATE_ALL 8'h11
`define ECID_CMD_REFRESH_ALL 8'h12
`define ECID_CMD_WRITE_ONE 8'h21
`define ECID_CMD_READ_ONE 8'h22

// ========================================
// mirror walk and storage
`define ECID_CFG_COUNT 9
`define ECID_IDX_RESERVED 4'h0
`define ECID_IDX_FIRST_RW 4'h1
`define ECID_IDX_LAST 4'h8
`define ECID_NVM_DEPTH 64
`define ECID_NVM_BLANK 8'hFF
`define ECID_RESET_BYTE 8'h00

// ========================================
// identification fields, values arbitrary
`define ECID_HW_REV_NIBBLE 4'h1
`define ECID_VERSION_NIBBLE 4'h2

`endif

/* rtl/ecid_nvm.v */
// eeprom cell array held in flip-flops
// assumes one writer and one combinational reader on the same clock
`timescale 1ns/1ps
`include "ecid_defs.vh"

module ecid_nvm (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [5:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [5:0] rd_addr,
  output wire [7:0] rd_data
);

  reg [7:0] cell_q [0:`ECID_NVM_DEPTH-1];
  integer i;

  // cells come up erased, then take single-byte writes
  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < `ECID_NVM_DEPTH; i = i + 1) begin
        cell_q[i] <= `ECID_NVM_BLANK;
      end
    end else if (wr_en) begin
      cell_q[wr_addr] <= wr_data;
    end
  end

  // read is combinational from the array
  assign rd_data = cell_q[rd_addr];

endmodule

/* rtl/ecid_top.v */
// eeprom command engine, configuration mirror and identification register
// assumes a synchronous byte-wide register port driven from SYS_CLK logic
`timescale 1ns/1ps
`include "ecid_defs.vh"

module ecid_top (
  input wire SYS_CLK,
  input wire RESET,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  output reg BUSY
);

  // ========================================
  // states
  localparam ST_IDLE = 2'b00;
  localparam ST_REFRESH = 2'b01;
  localparam ST_UPDATE = 2'b10;
  localparam ST_ONE = 2'b11;

  // ========================================
  // helper functions

  // eeprom address of a mirror index
  function [5:0] cfg_addr;
    input [3:0] idx;
    reg [7:0] full;
    begin
      if (idx == `ECID_IDX_RESERVED) begin
        full = `ECID_ADDR_CFG_RESERVED;
      end else begin
        full = `ECID_ADDR_CFG_FIRST + {4'h0, idx} - {4'h0, `ECID_IDX_FIRST_RW};
      end
      cfg_addr = full[5:0]; // eeprom array spans 64 bytes, upper bits are always zero
    end
  endfunction

  // true when the address is one of the mirrored bytes
  function is_cfg;
    input [7:0] addr;
    begin
      is_cfg = (addr == `ECID_ADDR_CFG_RESERVED) ||
               (addr >= `ECID_ADDR_CFG_FIRST && addr <= `ECID_ADDR_CFG_LAST);
    end
  endfunction

  // mirror index of a mirrored address
  function [3:0] cfg_idx;
    input [7:0] addr;
    reg [7:0] diff;
    begin
      diff = addr - `ECID_ADDR_CFG_FIRST + {4'h0, `ECID_IDX_FIRST_RW};
      if (addr == `ECID_ADDR_CFG_RESERVED) begin
        cfg_idx = `ECID_IDX_RESERVED;
      end else begin
        cfg_idx = diff[3:0];
      end
    end
  endfunction

  // ========================================
  // state
  reg [1:0] state_q;
  reg [3:0] idx_q;
  reg [7:0] cmd_q;
  reg [7:0] ptr_q;
  reg [7:0] buf_q;
  reg [7:0] mirror_q [0:`ECID_CFG_COUNT-1];
  integer k;

  wire [7:0] nvm_rd_data;
  wire [5:0] nvm_rd_addr;
  reg nvm_wr_en;
  reg [5:0] nvm_wr_addr;
  reg [7:0] nvm_wr_data;

  // pointer range accepted by the single-byte commands
  wire ptr_ok = (ptr_q <= `ECID_ADDR_USER_LAST) ||
                (ptr_q >= `ECID_ADDR_CFG_FIRST && ptr_q <= `ECID_ADDR_CFG_LAST);
  wire host_wr = REG_WR && (state_q == ST_IDLE);

  // ========================================
  // eeprom array
  ecid_nvm ecid_nvm_inst (
    .clk(SYS_CLK),
    .rst(RESET),
    .wr_en(nvm_wr_en),
    .wr_addr(nvm_wr_addr),
    .wr_data(nvm_wr_data),
    .rd_addr(nvm_rd_addr),
    .rd_data(nvm_rd_data)
  );

  // refresh walks the mirror set, otherwise the pointer selects
  assign nvm_rd_addr = (state_q == ST_REFRESH) ? cfg_addr(idx_q) : ptr_q[5:0];

  // eeprom write port: mirror store or buffer store
  always @* begin
    nvm_wr_en = 1'b0;
    nvm_wr_addr = ptr_q[5:0];
    nvm_wr_data = buf_q;
    if (state_q == ST_UPDATE) begin
      nvm_wr_en = 1'b1;
      nvm_wr_addr = cfg_addr(idx_q);
      nvm_wr_data = mirror_q[idx_q];
    end else if (state_q == ST_ONE && cmd_q == `ECID_CMD_WRITE_ONE) begin
      nvm_wr_en = 1'b1;
    end
  end

  // ========================================
  // command engine and register writes
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      state_q <= ST_REFRESH;
      idx_q <= `ECID_IDX_RESERVED;
      BUSY <= 1'b1;
      cmd_q <= `ECID_CMD_IDLE;
      ptr_q <= `ECID_RESET_BYTE;
      buf_q <= `ECID_RESET_BYTE;
      for (k = 0; k < `ECID_CFG_COUNT; k = k + 1) begin
        mirror_q[k] <= `ECID_RESET_BYTE;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (host_wr) begin
            if (REG_ADDR == `ECID_ADDR_BYTE_POINTER) begin
              ptr_q <= REG_WDATA;
            end else if (REG_ADDR == `ECID_ADDR_BYTE_BUFFER) begin
              buf_q <= REG_WDATA;
            end else if (is_cfg(REG_ADDR)) begin
              mirror_q[cfg_idx(REG_ADDR)] <= REG_WDATA;
            end else if (REG_ADDR == `ECID_ADDR_COMMAND_CODE) begin
              cmd_q <= REG_WDATA;
              if (REG_WDATA == `ECID_CMD_REFRESH_ALL) begin
                state_q <= ST_REFRESH;
                idx_q <= `ECID_IDX_RESERVED;
                BUSY <= 1'b1;
              end else if (REG_WDATA == `ECID_CMD_UPDATE_ALL) begin
                state_q <= ST_UPDATE;
                idx_q <= `ECID_IDX_FIRST_RW;
                BUSY <= 1'b1;
              end else if ((REG_WDATA == `ECID_CMD_WRITE_ONE || REG_WDATA == `ECID_CMD_READ_ONE) && ptr_ok) begin
                state_q <= ST_ONE;
                BUSY <= 1'b1;
              end
            end
          end
        end
        ST_REFRESH: begin
          mirror_q[idx_q] <= nvm_rd_data;
          idx_q <= idx_q + 4'h1;
          if (idx_q == `ECID_IDX_LAST) begin
            state_q <= ST_IDLE;
            idx_q <= `ECID_IDX_RESERVED;
            BUSY <= 1'b0;
          end
        end
        ST_UPDATE: begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == `ECID_IDX_LAST) begin
            state_q <= ST_IDLE;
            idx_q <= `ECID_IDX_RESERVED;
            BUSY <= 1'b0;
          end
        end
        default: begin
          if (cmd_q == `ECID_CMD_READ_ONE) begin
            buf_q <= nvm_rd_data;
          end
          state_q <= ST_IDLE;
          BUSY <= 1'b0;
        end
      endcase
    end
  end

  // ========================================
  // register read, one cycle after the strobe
  always @(posedge SYS_CLK) begin
    if (RESET) begin
      REG_RDATA <= `ECID_RESET_BYTE;
    end else if (REG_RD) begin
      if (REG_ADDR == `ECID_ADDR_BYTE_POINTER) begin
        REG_RDATA <= ptr_q;
      end else if (REG_ADDR == `ECID_ADDR_BYTE_BUFFER) begin
        REG_RDATA <= buf_q;
      end else if (REG_ADDR == `ECID_ADDR_COMMAND_CODE) begin
        REG_RDATA <= cmd_q;
      end else if (REG_ADDR == `ECID_ADDR_IDENTIFICATION) begin
        REG_RDATA <= {`ECID_HW_REV_NIBBLE, `ECID_VERSION_NIBBLE};
      end else if (is_cfg(REG_ADDR)) begin
        REG_RDATA <= mirror_q[cfg_idx(REG_ADDR)];
      end else begin
        REG_RDATA <= `ECID_RESET_BYTE; // unmapped reads zero
      end
    end
  end

endmodule

/* bench/ecid_checker.sv */
// timing and value checks on the register port of the command block
// assumes it is bound to ecid_top and sees only its ports
`timescale 1ns/1ps
module ecid_checker (
  input wire SYS_CLK,
  input wire RESET,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  input wire [7:0] REG_RDATA,
  input wire BUSY
);
  reg [7:0] ptr_q;
  wire cw = REG_WR && !BUSY && REG_ADDR == 8'h27;
  wire one = cw && (REG_WDATA == 8'h21 || REG_WDATA == 8'h22);
  wire ok = ptr_q <= 8'h2A || (ptr_q >= 8'h30 && ptr_q <= 8'h37);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // ========================================
  // shadow of the byte pointer
  always @(posedge SYS_CLK) begin
    if (RESET) ptr_q <= 8'h00;
    else if (REG_WR && !BUSY && REG_ADDR == 8'h25) ptr_q <= REG_WDATA;
  end
  // ========================================
  // properties
  property p_id; REG_RD && REG_ADDR == 8'h28 |=> REG_RDATA == 8'h12; endproperty
  a_id: assert property (p_id) else $error("identification value off");
  property p_gap; REG_RD && REG_ADDR == 8'h29 |=> REG_RDATA == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read not zero");
  property p_ro; REG_WR && !BUSY && REG_ADDR == 8'h28 |=> !BUSY; endproperty
  a_ro: assert property (p_ro) else $error("identification write had effect");
  property p_ref; cw && REG_WDATA == 8'h12 |=> BUSY [*8] ##1 BUSY ##1 !BUSY; endproperty
  a_ref: assert property (p_ref) else $error("refresh length off");
  property p_upd; cw && REG_WDATA == 8'h11 |=> BUSY [*8] ##1 !BUSY; endproperty
  a_upd: assert property (p_upd) else $error("update length off");
  property p_one; one && ok |=> BUSY ##1 !BUSY; endproperty
  a_one: assert property (p_one) else $error("single byte length off");
  property p_bad; one && !ok |=> !BUSY; endproperty
  a_bad: assert property (p_bad) else $error("bad pointer started work");
  property p_hold; !REG_RD |=> $stable(REG_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind ecid_top ecid_checker ecid_checker_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUSY(BUSY));

/* bench/ecid_host.sv */
// host model issuing register reads and writes
// assumes the design samples on the rising edge
`timescale 1ns/1ps
module ecid_host (
  input wire clk,
  input wire [7:0] rdata,
  input wire busy,
  output reg [7:0] addr,
  output reg [7:0] wdata,
  output reg wr,
  output reg rd
);
  initial {addr, wdata, wr, rd} = 18'h0;
  // one write strobe; released lines show inverted values
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk) {addr, wdata, wr} = {a, d, 1'b1};
      @(negedge clk) {addr, wdata, wr} = {~a, ~d, 1'b0};
    end
  endtask
  // one read strobe; data valid one edge later
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      @(negedge clk) {addr, rd} = {a, 1'b1};
      @(negedge clk) {addr, rd} = {~a, 1'b0};
      d = rdata;
    end
  endtask
  // bounded wait for the engine to go idle
  task idle;
    repeat (20) if (busy) @(negedge clk);
  endtask
endmodule

/* bench/ecid_top_test.sv */
// self-checking bench for the command and identification block
// assumes ecid_top, ecid_host and the bound checker
`timescale 1ns/1ps
module ecid_top_test;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  wire [7:0] a, wd, rdat;
  wire wr, rd, busy;
  reg [7:0] v, i;
  integer miscompares = 0;
  integer n_compared = 0;
  always #20 sys_clk = ~sys_clk;
  ecid_top ecid_top_inst (.SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(a), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .BUSY(busy));
  ecid_host ecid_host_inst (.clk(sys_clk), .rdata(rdat), .busy(busy), .addr(a), .wdata(wd),
    .wr(wr), .rd(rd));
  // ========================================
  // helpers
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rc(input [7:0] ad, input [7:0] e);
    begin
      ecid_host_inst.rd_reg(ad, v);
      chk(v, e);
    end
  endtask
  task cmd(input [7:0] c);
    begin
      ecid_host_inst.wr_reg(8'h27, c);
      ecid_host_inst.idle;
      chk({7'h00, busy}, 8'h00);
    end
  endtask
  task one(input [7:0] p, input [7:0] d);
    begin
      ecid_host_inst.wr_reg(8'h25, p);
      ecid_host_inst.wr_reg(8'h26, d);
      cmd(8'h21);
      ecid_host_inst.wr_reg(8'h26, 8'h00);
      cmd(8'h22);
      rc(8'h26, d);
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d, wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // ========================================
  // watchdog
  initial begin
    #200000;
    miscompares = miscompares + 1;
    end_sim;
  end
  // ========================================
  // tests
  initial begin
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    ecid_host_inst.idle;
    chk({7'h00, busy}, 8'h00);
    rc(8'h28, 8'h12);
    ecid_host_inst.wr_reg(8'h28, 8'h5A);
    rc(8'h28, 8'h12);
    rc(8'h29, 8'h00);
    rc(8'h2B, 8'hFF);
    $display("id test done");
    for (i = 0; i < 8; i = i + 1) ecid_host_inst.wr_reg(8'h30 + i, 8'hA0 + i);
    ecid_host_inst.wr_reg(8'h2B, 8'h3C);
    rc(8'h2B, 8'h3C);
    cmd(8'h11);
    for (i = 0; i < 8; i = i + 1) ecid_host_inst.wr_reg(8'h30 + i, 8'h00);
    cmd(8'h12);
    for (i = 0; i < 8; i = i + 1) rc(8'h30 + i, 8'hA0 + i);
    rc(8'h2B, 8'hFF);
    rc(8'h27, 8'h12);
    $display("mirror test done");
    one(8'h00, 8'h55);
    one(8'h2A, 8'h66);
    one(8'h30, 8'h99);
    ecid_host_inst.wr_reg(8'h25, 8'h2B);
    ecid_host_inst.wr_reg(8'h26, 8'h77);
    cmd(8'h21);
    cmd(8'h12);
    rc(8'h2B, 8'hFF);
    rc(8'h30, 8'h99);
    ecid_host_inst.wr_reg(8'h25, 8'h38);
    cmd(8'h22);
    rc(8'h26, 8'h77);
    $display("single byte test done");
    end_sim;
  end
endmodule
